// ==== tb_uart_line_status_and_irq.sv ====
`timescale 1ns/1ps
module tb_uart_line_status_and_irq;
  import ulsi_pkg::*;
  logic        clk = 1'b0;        // 250 mhz
  logic        sys_rst = 1'b1;    // sync reset
  logic [31:0] addr = 32'h0;      // bus address
  logic [31:0] wr_data = 32'h0;   // bus write data
  logic        wr_en = 1'b0;      // write strobe
  logic        rd_en = 1'b0;      // read strobe
  logic [31:0] rd_data;           // read answer
  logic        rx_line;           // remote to device
  logic        tx_line;           // device to remote
  logic        rts_n;             // request to send
  logic        dtr_n;             // terminal ready
  logic        irq;               // interrupt level
  logic [31:0] v;                 // last read value
  int          bad_count = 0;     // mismatches
  int          n_tests = 0;       // comparisons
  int          cyc = 0;           // cycles run
  int          n;                 // scratch count

  ulsi_uart dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .serial_rx_pin(rx_line), .serial_tx_pin(tx_line), .rts_n(rts_n),
    .dtr_n(dtr_n), .irq(irq));
  ulsi_remote #(.BIT(2)) far (.clk(clk), .serial_tx_pin(tx_line),
    .serial_rx_pin(rx_line));

  // free-running clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end
  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // masked compare of a bus word
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input logic [31:0] m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // compare of a single pin
  task automatic chk_pin(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= {24'h000000, d};
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // one-cycle read strobe; the answer stands only in the next cycle
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask
  // read and compare the bits chosen by m; upper bits must be zero
  task automatic rdc(input logic [31:0] a, input logic [7:0] e,
                     input logic [7:0] m);
    rd(a);
    chk(v, {24'h000000, e}, {24'hffffff, m});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk_pin(rts_n, 1'b1);
    chk_pin(dtr_n, 1'b1);
    chk_pin(irq, 1'b0);
    rdc(ADDR_LSR, 8'h60, 8'hff);
    rdc(ADDR_IID, 8'h01, 8'hff);
    rdc(ADDR_LCR, 8'h00, 8'hff);
    rdc(ADDR_IEN, 8'h00, 8'hff);
    done("reset");
    // reserved bits dropped, modem pins follow the bits inverted
    wr(ADDR_LCR, 8'hee);
    #1;
    chk_pin(rts_n, 1'b0);
    chk_pin(dtr_n, 1'b1);
    rdc(ADDR_LCR, 8'h02, 8'hff);
    wr(ADDR_LCR, 8'h01);
    #1;
    chk_pin(rts_n, 1'b1);
    chk_pin(dtr_n, 1'b0);
    wr(ADDR_LSR, 8'hff);
    wr(ADDR_IID, 8'h00);
    rdc(ADDR_LSR, 8'h60, 8'hff);
    rdc(ADDR_IID, 8'h01, 8'hff);
    rdc(32'hffff0820, 8'h00, 8'hff);
    wr(ADDR_LCR, 8'h00);
    // forced break pulls the idle line low, and lets go again
    wr(ADDR_FMT, 8'h40);
    #1;
    chk_pin(tx_line, 1'b0);
    wr(ADDR_FMT, 8'h00);
    #1;
    chk_pin(tx_line, 1'b1);
    done("control");
    // divisor access hides the enable register; divisor of 2
    wr(ADDR_IEN, 8'h05);
    wr(ADDR_FMT, 8'h80);
    wr(ADDR_IEN, 8'h00);
    wr(ADDR_DATA, 8'h02);
    rdc(ADDR_IEN, 8'h00, 8'hff);
    wr(ADDR_FMT, 8'h03);
    rdc(ADDR_IEN, 8'h05, 8'hff);
    wr(ADDR_IEN, 8'h00);
    done("divisor");
    // loopback: pin stays high, byte comes back inside
    wr(ADDR_LCR, 8'h10);
    wr(ADDR_DATA, 8'ha5);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (tx_line !== 1'b1) n++;
    end
    chk(32'(n), 32'h0, 32'hffffffff);
    rdc(ADDR_LSR, 8'h61, 8'hff);
    rdc(ADDR_DATA, 8'ha5, 8'hff);
    rdc(ADDR_LSR, 8'h60, 8'hff);
    wr(ADDR_LCR, 8'h00);
    done("loopback");
    // transmit: holding empties while the shifter still runs
    fork
      far.take();
      begin
        wr(ADDR_DATA, 8'h3c);
        rdc(ADDR_LSR, 8'h20, 8'hff);
      end
    join
    chk({24'h000000, far.got}, 32'h3c, 32'hffffffff);
    idle(4);
    rdc(ADDR_LSR, 8'h60, 8'hff);
    done("transmit");
    // receive, then overrun by a second unread byte
    far.send(8'h11, 1'b0, 1'b0, 1'b1);
    idle(2);
    rdc(ADDR_LSR, 8'h61, 8'hff);
    far.send(8'h22, 1'b0, 1'b0, 1'b1);
    idle(2);
    rdc(ADDR_LSR, 8'h63, 8'hff);
    rdc(ADDR_LSR, 8'h61, 8'hff);
    rdc(ADDR_DATA, 8'h22, 8'hff);
    rdc(ADDR_LSR, 8'h60, 8'hff);
    done("receive");
    // bad stop, then bad and good parity, then a long break
    far.send(8'h33, 1'b0, 1'b0, 1'b0);
    idle(2);
    rdc(ADDR_LSR, 8'h08, 8'h08);
    rdc(ADDR_LSR, 8'h00, 8'h08);
    rd(ADDR_DATA);
    wr(ADDR_FMT, 8'h1b);
    far.send(8'h07, 1'b1, 1'b0, 1'b1);
    idle(2);
    rdc(ADDR_LSR, 8'h04, 8'h04);
    rd(ADDR_DATA);
    far.send(8'h07, 1'b1, 1'b1, 1'b1);
    idle(2);
    rdc(ADDR_LSR, 8'h01, 8'h05);
    rd(ADDR_DATA);
    wr(ADDR_FMT, 8'h03);
    far.hold_low(40);
    idle(30);
    rdc(ADDR_LSR, 8'h10, 8'h10);
    rdc(ADDR_LSR, 8'h00, 8'h10);
    rd(ADDR_DATA);
    done("errors");
    // interrupt sources, priority, sticky clear and mask
    wr(ADDR_IMSK, 8'h07);
    wr(ADDR_IEN, 8'h02);
    idle(1);
    #1;
    chk_pin(irq, 1'b1);
    rdc(ADDR_IID, 8'h02, 8'hff);
    wr(ADDR_IEN, 8'h03);
    far.send(8'h44, 1'b0, 1'b0, 1'b1);
    idle(2);
    rdc(ADDR_IID, 8'h04, 8'hff);
    wr(ADDR_IEN, 8'h07);
    far.send(8'h55, 1'b0, 1'b0, 1'b0);
    idle(2);
    rdc(ADDR_IID, 8'h06, 8'hff);
    rd(ADDR_LSR);
    rd(ADDR_DATA);
    rdc(ADDR_IID, 8'h02, 8'hff);
    wr(ADDR_IEN, 8'h00);
    #1;
    chk_pin(irq, 1'b1);
    wr(ADDR_ISTS, 8'h07);
    #1;
    chk_pin(irq, 1'b0);
    rdc(ADDR_IID, 8'h01, 8'hff);
    wr(ADDR_IMSK, 8'h00);
    wr(ADDR_IEN, 8'h02);
    idle(2);
    #1;
    chk_pin(irq, 1'b0);
    done("interrupts");
    tally_and_finish();
  end
endmodule

// ==== ulsi_pkg.sv ====
package ulsi_pkg;
  // byte addresses of the register words
  localparam logic [31:0] ADDR_DATA = 32'hffff0800; // rx/tx, div low
  localparam logic [31:0] ADDR_IEN  = 32'hffff0804; // irq en, div high
  localparam logic [31:0] ADDR_IID  = 32'hffff0808; // irq ident
  localparam logic [31:0] ADDR_FMT  = 32'hffff080c; // format control
  localparam logic [31:0] ADDR_LCR  = 32'hffff0810; // line control
  localparam logic [31:0] ADDR_LSR  = 32'hffff0814; // line status
  localparam logic [31:0] ADDR_ISTS = 32'hffff0818; // sticky irq status
  localparam logic [31:0] ADDR_IMSK = 32'hffff081c; // irq mask
  // line control fields
  localparam int LC_LOOP = 4;
  localparam int LC_RTS  = 1;
  localparam int LC_DTR  = 0;
  localparam logic [7:0] LCR_MASK = 8'h13; // writable bits
  // format control fields
  localparam int FMT_DIVISOR_ACCESS_BIT = 7;
  localparam int FMT_BRK  = 6;
  localparam int FMT_SP   = 5;
  localparam int FMT_EPS  = 4;
  localparam int FMT_PEN  = 3;
  localparam int FMT_STOP = 2;
  // line status fields
  localparam int LS_TX_ALL_EMPTY_FLAG = 6;
  localparam int LS_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int LS_BI   = 4;
  localparam int LS_FE   = 3;
  localparam int LS_PE   = 2;
  localparam int LS_OE   = 1;
  localparam int LS_DR   = 0;
  // interrupt enable fields, same layout in sticky status and mask
  localparam int IE_LINE = 2;
  localparam int IE_TX   = 1;
  localparam int IE_RX   = 0;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] LSR_RST = 8'h60;
  localparam logic [7:0] IID_RST = 8'h01;
  // ident source codes for bits 2:1
  localparam logic [1:0] IID_LINE = 2'h3;
  localparam logic [1:0] IID_RX   = 2'h2;
  localparam logic [1:0] IID_TX   = 2'h1;
  // longest frame: start, 8 data, parity, 2 stop
  localparam logic [19:0] FRAME_BITS = 20'h0000c;
  // serial state machines
  typedef enum logic [2:0] {
    SM_IDLE  = 3'b000,
    SM_START = 3'b001,
    SM_DATA  = 3'b010,
    SM_PAR   = 3'b011,
    SM_STOP  = 3'b100
  } ulsi_sm_e;
endpackage

// ==== ulsi_remote.sv ====
`timescale 1ns/1ps
// far-end serial device: sends frames, captures what the uart sends
module ulsi_remote #(
  parameter int BIT = 2 // cycles per bit, must match the divisor
) (
  input  wire logic clk,           // device clock
  input  wire logic serial_tx_pin, // line from the device
  output logic      serial_rx_pin  // line to the device, idle high
);
  logic [7:0] got; // last byte taken off the line
  initial serial_rx_pin = 1'b1;
  // one bit time, changed just after an edge
  task automatic put(input logic b);
    serial_rx_pin <= b;
    repeat (BIT) @(posedge clk);
  endtask
  // start, 8 data lsb first, optional parity, stop level as asked
  task automatic send(input logic [7:0] b, input logic pe,
                      input logic p, input logic stop);
    @(posedge clk);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    if (pe) begin
      put(p);
    end
    put(stop);
    // a low stop bit reads as a fresh start to the receiver; stay idle
    // until that phantom character has run out
    repeat (stop ? 1 : 12) put(1'b1);
  endtask
  // line held low far longer than any frame
  task automatic hold_low(input int n);
    @(posedge clk);
    serial_rx_pin <= 1'b0;
    repeat (n) @(posedge clk);
    serial_rx_pin <= 1'b1;
  endtask
  // catch one frame from the device; gives up after 100 cycles
  task automatic take();
    int w;
    w = 0;
    got = 8'hxx;
    while (serial_tx_pin !== 1'b0 && w < 100) begin
      @(posedge clk);
      #1;
      w++;
    end
    // sample the first cycle of every data bit
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      #1;
      got[i] = serial_tx_pin;
    end
    repeat (BIT) @(posedge clk);
  endtask
endmodule

// ==== ulsi_uart.sv ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module ulsi_uart
  import ulsi_pkg::*;
(
  input  wire logic        clk,           // 250 mhz clock
  input  wire logic        sys_rst,       // sync reset, active high
  input  wire logic        ce,            // clock enable, low freezes
  input  wire logic [31:0] addr,          // register byte address
  input  wire logic [31:0] wr_data,       // write data, low byte used
  input  wire logic        wr_en,         // write strobe
  input  wire logic        rd_en,         // read strobe
  output logic      [31:0] rd_data,       // read data, cycle after
  input  wire logic        serial_rx_pin, // serial input
  output logic             serial_tx_pin, // serial output
  output logic             rts_n,         // request to send, low
  output logic             dtr_n,         // terminal ready, low
  output logic             irq            // level interrupt
);

  // whole state of the block
  typedef struct packed {
    logic [7:0]  line_ctrl;  // loopback and modem overrides
    logic [7:0]  irq_en;     // per-source enables
    logic [7:0]  fmt;        // format control
    logic [7:0]  div_lo;     // divisor low byte
    logic [7:0]  div_hi;     // divisor high byte
    logic [7:0]  tx_hold;    // transmit holding byte
    logic        hold_full;  // holding byte pending
    ulsi_sm_e    tx_state;   // transmit sequencer
    logic [7:0]  tx_shift;   // transmit shifter
    logic [15:0] tx_cnt;     // transmit bit timer
    logic [2:0]  tx_bit;     // data or stop bit index
    logic        tx_par;     // running transmit parity
    logic        tx_line;    // shifter line level
    ulsi_sm_e    rx_state;   // receive sequencer
    logic [15:0] rx_cnt;     // receive bit timer
    logic [2:0]  rx_bit;     // data bit index
    logic [7:0]  rx_shift;   // receive shifter
    logic        rx_par;     // running receive parity
    logic        rx_perr;    // parity miss of frame in flight
    logic [7:0]  rx_buf;     // receive buffer byte
    logic        rx_ready;   // buffer holds a character
    logic        brk;        // break seen
    logic        fe;         // framing error
    logic        pe;         // parity error
    logic        oe;         // overrun error
    logic [19:0] low_cnt;    // consecutive low input cycles
    logic [2:0]  irq_sts;    // sticky interrupt status
    logic [2:0]  irq_mask;   // interrupt mask
    logic [7:0]  rd_byte;    // registered read answer
  } ulsi_state_s;

  localparam ulsi_state_s ST_RST = '{
    line_ctrl: LCR_RST,
    irq_en:    IEN_RST,
    fmt:       FMT_RST,
    div_lo:    DIV_RST,
    div_hi:    DIV_RST,
    tx_state:  SM_IDLE,
    rx_state:  SM_IDLE,
    tx_line:   1'b1,
    default:   '0
  };

  ulsi_state_s s;          // registered state
  ulsi_state_s next_s;     // next state
  logic        divisor_access_bit;       // divisor access selected
  logic [15:0] div_eff;    // bit period in cycles, never zero
  logic [2:0]  wlen_m1;    // data bits minus one
  logic        tx_int;     // internal transmit level
  logic        rx_in;      // receive level after loopback mux
  logic        tx_tick;    // transmit bit boundary
  logic        rx_tick;    // receive sample point
  logic [19:0] brk_lim;    // low cycles of the longest frame
  logic [7:0]  lsr;        // line status view
  logic        pend_line;  // line status source pending
  logic        pend_rx;    // receive full source pending
  logic        pend_tx;    // holding empty source pending
  logic [7:0]  ident;      // identification view
  logic        rx_done;    // character lands this cycle
  logic        brk_hit;    // break detected this cycle
  logic        rx_rd_clr;  // software reads receive buffer
  logic [15:0] rx_half;    // cycles from start edge to sample point
  logic        thr_wr;     // holding register write strobe

  // parity bit for an accumulated data parity
  function automatic logic par_bit(input logic p, input logic [7:0] f);
    par_bit = f[FMT_SP] ? f[FMT_EPS] : (f[FMT_EPS] ? p : ~p);
  endfunction

  // static decodes of configuration and the bit timers
  assign divisor_access_bit    = s.fmt[FMT_DIVISOR_ACCESS_BIT];
  assign div_eff = ({s.div_hi, s.div_lo} == 16'h0000) ?
                   16'h0001 : {s.div_hi, s.div_lo};
  assign wlen_m1 = {1'b1, s.fmt[1:0]};
  assign tx_tick = (s.tx_cnt == 16'h0000);
  assign rx_tick = (s.rx_cnt == 16'h0000);
  assign brk_lim = {4'h0, div_eff} * FRAME_BITS;
  // sample just before mid-bit so a two-cycle bit still lands inside
  assign rx_half = (div_eff - 16'h0001) >> 1;
  // break forces the line low; loopback feeds it straight back
  assign tx_int  = s.fmt[FMT_BRK] ? 1'b0 : s.tx_line;
  assign rx_in   = s.line_ctrl[LC_LOOP] ? tx_int : serial_rx_pin;

  // line status is built from state, so it cannot be written
  assign lsr = {1'b0,
                (!s.hold_full && s.tx_state == SM_IDLE),
                !s.hold_full,
                s.brk, s.fe, s.pe, s.oe, s.rx_ready};

  // enabled sources and the priority encoder behind ident
  assign pend_line = s.irq_en[IE_LINE] && (s.fe || s.pe || s.oe);
  assign pend_tx   = s.irq_en[IE_TX] && lsr[LS_TX_HOLDING_EMPTY_FLAG];
  assign pend_rx   = s.irq_en[IE_RX] && s.rx_ready;
  always_comb begin
    if (pend_line) begin
      ident = {5'h00, IID_LINE, 1'b0};
    end else if (pend_rx) begin
      ident = {5'h00, IID_RX, 1'b0};
    end else if (pend_tx) begin
      ident = {5'h00, IID_TX, 1'b0};
    end else begin
      ident = IID_RST;
    end
  end

  // pins and interrupt are gated from flops only, no input feeds them
  assign serial_tx_pin = s.line_ctrl[LC_LOOP] ? 1'b1 : tx_int;
  assign rts_n   = ~s.line_ctrl[LC_RTS];
  assign dtr_n   = ~s.line_ctrl[LC_DTR];
  assign irq     = |(s.irq_sts & s.irq_mask);
  assign rd_data = {24'h000000, s.rd_byte};
  assign rx_rd_clr = rd_en && addr == ADDR_DATA && !divisor_access_bit;
  assign thr_wr    = wr_en && addr == ADDR_DATA && !divisor_access_bit;

  // next state: read clears first, then sequencers set, then writes
  always_comb begin
    next_s  = s;
    rx_done = 1'b0;
    brk_hit = 1'b0;
    next_s.rd_byte = 8'h00;
    // read answers and their side effects
    if (rd_en) begin
      case (addr)
        ADDR_DATA: begin
          next_s.rd_byte = divisor_access_bit ? s.div_lo : s.rx_buf;
          if (!divisor_access_bit) begin
            next_s.rx_ready = 1'b0;
          end
        end
        ADDR_IEN:  next_s.rd_byte = divisor_access_bit ? s.div_hi : s.irq_en;
        ADDR_IID:  next_s.rd_byte = ident;
        ADDR_FMT:  next_s.rd_byte = s.fmt;
        ADDR_LCR:  next_s.rd_byte = s.line_ctrl;
        ADDR_LSR: begin
          next_s.rd_byte = lsr;
          // error flags clear on their own once software has seen them
          next_s.brk = 1'b0;
          next_s.fe  = 1'b0;
          next_s.pe  = 1'b0;
          next_s.oe  = 1'b0;
        end
        ADDR_ISTS: next_s.rd_byte = {5'h00, s.irq_sts};
        ADDR_IMSK: next_s.rd_byte = {5'h00, s.irq_mask};
        default:   next_s.rd_byte = 8'h00;
      endcase
    end
    // transmit bit timer
    if (s.tx_state != SM_IDLE) begin
      next_s.tx_cnt = tx_tick ? div_eff - 16'h0001 : s.tx_cnt - 16'h0001;
    end
    // transmit sequencer
    unique case (s.tx_state)
      SM_IDLE: begin
        next_s.tx_line = 1'b1;
        if (s.hold_full) begin
          next_s.tx_shift  = s.tx_hold;
          next_s.hold_full = 1'b0;
          next_s.tx_state  = SM_START;
          next_s.tx_cnt    = div_eff - 16'h0001;
          next_s.tx_line   = 1'b0;
          next_s.tx_par    = 1'b0;
          next_s.tx_bit    = 3'h0;
        end
      end
      SM_START: begin
        if (tx_tick) begin
          next_s.tx_state = SM_DATA;
          next_s.tx_line  = s.tx_shift[0];
        end
      end
      SM_DATA: begin
        if (tx_tick) begin
          next_s.tx_par   = s.tx_par ^ s.tx_shift[0];
          next_s.tx_shift = s.tx_shift >> 1;
          if (s.tx_bit == wlen_m1) begin
            next_s.tx_bit = 3'h0;
            if (s.fmt[FMT_PEN]) begin
              next_s.tx_state = SM_PAR;
              next_s.tx_line  = par_bit(s.tx_par ^ s.tx_shift[0], s.fmt);
            end else begin
              next_s.tx_state = SM_STOP;
              next_s.tx_line  = 1'b1;
            end
          end else begin
            next_s.tx_bit  = s.tx_bit + 3'h1;
            next_s.tx_line = s.tx_shift[1];
          end
        end
      end
      SM_PAR: begin
        if (tx_tick) begin
          next_s.tx_state = SM_STOP;
          next_s.tx_line  = 1'b1;
        end
      end
      SM_STOP: begin
        // a second stop bit is sent when selected
        if (tx_tick) begin
          if (s.fmt[FMT_STOP] && s.tx_bit == 3'h0) begin
            next_s.tx_bit = 3'h1;
          end else begin
            next_s.tx_state = SM_IDLE;
          end
        end
      end
      default: next_s.tx_state = SM_IDLE;
    endcase
    // receive bit timer
    if (s.rx_state != SM_IDLE) begin
      next_s.rx_cnt = rx_tick ? div_eff - 16'h0001 : s.rx_cnt - 16'h0001;
    end
    // receive sequencer, sampling near mid-bit
    unique case (s.rx_state)
      SM_IDLE: begin
        if (!rx_in) begin
          // the low level is seen one cycle late, so the sample point
          // is pulled one cycle in; at short bit times the detecting
          // sample itself stands in for the start check
          next_s.rx_bit   = 3'h0;
          next_s.rx_par   = 1'b0;
          next_s.rx_perr  = 1'b0;
          if (rx_half == 16'h0000) begin
            next_s.rx_state = SM_DATA;
            next_s.rx_cnt   = div_eff - 16'h0001;
          end else begin
            next_s.rx_state = SM_START;
            next_s.rx_cnt   = rx_half - 16'h0001;
          end
        end
      end
      SM_START: begin
        // a glitch shorter than half a bit is dropped
        if (rx_tick) begin
          next_s.rx_state = rx_in ? SM_IDLE : SM_DATA;
        end
      end
      SM_DATA: begin
        if (rx_tick) begin
          next_s.rx_shift = {rx_in, s.rx_shift[7:1]};
          next_s.rx_par   = s.rx_par ^ rx_in;
          if (s.rx_bit == wlen_m1) begin
            next_s.rx_state = s.fmt[FMT_PEN] ? SM_PAR : SM_STOP;
          end else begin
            next_s.rx_bit = s.rx_bit + 3'h1;
          end
        end
      end
      SM_PAR: begin
        if (rx_tick) begin
          next_s.rx_perr  = (rx_in != par_bit(s.rx_par, s.fmt));
          next_s.rx_state = SM_STOP;
        end
      end
      SM_STOP: begin
        // only the first stop bit is checked
        if (rx_tick) begin
          rx_done         = 1'b1;
          next_s.rx_state = SM_IDLE;
          next_s.rx_buf   = s.rx_shift >> (3'h7 - wlen_m1);
          // overrun looks at the flag after this cycle's read
          if (next_s.rx_ready) begin
            next_s.oe = 1'b1;
          end
          if (!rx_in) begin
            next_s.fe = 1'b1;
          end
          if (s.rx_perr) begin
            next_s.pe = 1'b1;
          end
          next_s.rx_ready = 1'b1;
        end
      end
      default: next_s.rx_state = SM_IDLE;
    endcase
    // break: low for one cycle past the longest frame, set once
    if (rx_in) begin
      next_s.low_cnt = 20'h00000;
    end else if (s.low_cnt != 20'hfffff) begin
      next_s.low_cnt = s.low_cnt + 20'h00001;
    end
    if (!rx_in && s.low_cnt == brk_lim) begin
      brk_hit    = 1'b1;
      next_s.brk = 1'b1;
    end
    // register writes
    if (wr_en) begin
      case (addr)
        ADDR_DATA: begin
          if (divisor_access_bit) begin
            next_s.div_lo = wr_data[7:0];
          end else begin
            // writing while full replaces the pending byte
            next_s.tx_hold   = wr_data[7:0];
            next_s.hold_full = 1'b1;
          end
        end
        ADDR_IEN: begin
          if (divisor_access_bit) begin
            next_s.div_hi = wr_data[7:0];
          end else begin
            next_s.irq_en = {5'h00, wr_data[2:0]};
          end
        end
        ADDR_FMT:  next_s.fmt = wr_data[7:0];
        ADDR_LCR:  next_s.line_ctrl = wr_data[7:0] & LCR_MASK;
        ADDR_ISTS: next_s.irq_sts = s.irq_sts & ~wr_data[2:0];
        ADDR_IMSK: next_s.irq_mask = wr_data[2:0];
        default: ;
      endcase
    end
    // pending sources set sticky bits after the clear, so set wins
    next_s.irq_sts[IE_LINE] = next_s.irq_sts[IE_LINE] | pend_line;
    next_s.irq_sts[IE_TX]   = next_s.irq_sts[IE_TX] | pend_tx;
    next_s.irq_sts[IE_RX]   = next_s.irq_sts[IE_RX] | pend_rx;
  end

  // single state register; the clock enable holds everything
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // checks on the block's own outputs and state
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_thr_write;
    ce && thr_wr;
  endsequence
  // holding register free and shifter idle, so the byte moves on next
  sequence s_thr_write_idle;
    s_thr_write ##0 (s.tx_state == SM_IDLE && !s.hold_full);
  endsequence
  sequence s_rx_read;
    ce && rx_rd_clr && !rx_done;
  endsequence

  property p_loop_high;
    s.line_ctrl[LC_LOOP] |-> serial_tx_pin;
  endproperty
  a_loop_high: assert property (p_loop_high)
    else $error("loopback did not hold serial output high");
  property p_rts;
    rts_n == !s.line_ctrl[LC_RTS];
  endproperty
  a_rts: assert property (p_rts)
    else $error("request to send not inverse of control bit");
  property p_dtr;
    dtr_n == !s.line_ctrl[LC_DTR];
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("terminal ready not inverse of control bit");
  property p_tx_all_empty_flag_clr;
    s_thr_write |=> !lsr[LS_TX_ALL_EMPTY_FLAG];
  endproperty
  a_tx_all_empty_flag_clr: assert property (p_tx_all_empty_flag_clr)
    else $error("all-empty flag stayed set after holding write");
  property p_tx_holding_empty_flag_clr;
    // a frozen cycle or a fresh write keeps the holding register full
    s_thr_write_idle |=> !lsr[LS_TX_HOLDING_EMPTY_FLAG] ##1
      (lsr[LS_TX_HOLDING_EMPTY_FLAG] || !$past(ce) || $past(thr_wr));
  endproperty
  a_tx_holding_empty_flag_clr: assert property (p_tx_holding_empty_flag_clr)
    else $error("holding-empty flag wrong around holding write");
  property p_brk;
    ce && brk_hit |=> s.brk;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break flag not set after long low input");
  property p_ovr;
    ce && rx_done && s.rx_ready && !rx_rd_clr |=> s.oe && s.rx_ready;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not flagged on unread character");
  property p_rx_read;
    s_rx_read |=> !s.rx_ready;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("data ready not cleared by buffer read");
  property p_reset_vals;
    $fell(sys_rst) |-> lsr == LSR_RST && ident == IID_RST &&
                       s.line_ctrl == LCR_RST && s.irq_en == IEN_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register values wrong after reset");
  property p_line_id;
    s.irq_en[IE_LINE] && (|lsr[LS_FE:LS_OE]) |-> ident == 8'h06;
  endproperty
  a_line_id: assert property (p_line_id)
    else $error("line status source not reported first");
  property p_tx_id;
    s.irq_en[IE_TX] && lsr[LS_TX_HOLDING_EMPTY_FLAG] && !pend_line && !pend_rx
      |-> ident == 8'h02;
  endproperty
  a_tx_id: assert property (p_tx_id)
    else $error("holding-empty source not reported");
  property p_rx_id;
    s.irq_en[IE_RX] && s.rx_ready && !pend_line |-> ident == 8'h04;
  endproperty
  a_rx_id: assert property (p_rx_id)
    else $error("receive-full source not reported");
  property p_nint;
    ident[0] == !(pend_line || pend_rx || pend_tx);
  endproperty
  a_nint: assert property (p_nint)
    else $error("ident bit 0 disagrees with pending sources");
  property p_ien_hidden;
    ce && wr_en && addr == ADDR_IEN && divisor_access_bit |=> $stable(s.irq_en);
  endproperty
  a_ien_hidden: assert property (p_ien_hidden)
    else $error("enable register written while divisor access set");

endmodule
